// ===== core/pts_sequencer.sv
/*
  pts_sequencer: point-table positioning sequencer. Holds the table, accepts a
  start and entry number from the host, issues move commands to the motion
  controller, waits for completion, dwells and chains or stops.
  assumes: start, entry number and motion-done arrive as pins; table writes,
  mode bits and the remote-register entry come from logic on clk.
*/
// Operation
// RULE1: incremental target is present position plus scaled movement amount.
// RULE2: incremental amount is unsigned up to 999999, scaled by ten to the exponent.
// RULE3: each entry's command speed goes out with its move.
// RULE4: each entry's acceleration time, 0 to 20000 ms, goes out with its move.
// RULE5: each entry's deceleration time, 0 to 20000 ms, goes out with its move.
// RULE6: after a move completes, wait the entry's dwell before the next entry.
// RULE7: incremental auxiliary code 0 stops and waits for a new start.
// RULE8: incremental auxiliary code 1 chains into the next entry.
// RULE9: completion code 0 to 99 is presented when the entry's move finishes.
// RULE10: absolute auxiliary code 1 or 3 chains into the next entry.
// RULE11: absolute code 0 or 2 needs a fresh host start for the next entry.
// RULE12: completion code only drives the extension digital outputs.
// RULE13: S-curve time comes from one global setting, not from entries.
// RULE14: absolute target is the scaled position, referenced to home.
// RULE15: up to 255 stored entries selected by number.
// RULE16: host selects a stored entry or fills the remote-register entry, then starts.
// RULE17: starts are ignored unless the sequencer is idle.
`timescale 1ns/1ps
module pts_sequencer #(
  parameter int TICK_CYCLES = pts_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_pin,
  input wire logic [pts_pkg::IDX_W-1:0] point_sel_pin,
  input wire logic motion_done_pin,
  input wire logic abs_mode,
  input wire logic [pts_pkg::EXP_W-1:0] position_scale_exponent,
  input wire logic [pts_pkg::TIME_W-1:0] s_curve_ms,
  input wire logic ext_io_present,
  input wire pts_pkg::pts_entry_t direct_entry,
  input wire logic tbl_wr_en,
  input wire logic [pts_pkg::IDX_W-1:0] tbl_wr_idx,
  input wire pts_pkg::pts_entry_t tbl_wr_data,
  output pts_pkg::pts_move_t move_cmd_q,
  output logic move_start_q,
  output logic busy_q,
  output logic [pts_pkg::IDX_W-1:0] cur_idx_q,
  output logic signed [pts_pkg::CMD_W-1:0] present_pos_q,
  output logic [pts_pkg::MCODE_W-1:0] mcode_q,
  output logic mcode_valid_q,
  output logic pos_done_q,
  output logic wr_reject_q,
  output logic entry_err_q
);
  pts_pkg::pts_state_t state_q;
  pts_pkg::pts_entry_t tbl_q [1:pts_pkg::ENTRIES];
  pts_pkg::pts_entry_t ent_q, ent_rd;
  logic abs_q;
  logic [pts_pkg::TIME_W-1:0] dwell_cnt_q;
  logic start_s, start_prev_q, start_rise;
  logic done_s, done_prev_q, done_rise;
  logic [pts_pkg::IDX_W-1:0] sel_s;
  logic tick, tick_clr, wr_ok, chain_ok, dwell_end, inc_bad;
  logic signed [pts_pkg::CMD_W-1:0] scaled, inc_sum, target_d;

  // pins cross in through the agreement synchroniser
  pts_sync #(.W(pts_pkg::IDX_W + 2)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({start_pin, motion_done_pin, point_sel_pin}),
    .dout({start_s, done_s, sel_s})
  );

  // dwell time base restarts when a move completes
  assign tick_clr = (state_q == pts_pkg::ST_MOVE) && done_rise;
  pts_ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .clear(tick_clr),
    .tick(tick)
  );

  // edge detection on the settled pin levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_s;
      done_prev_q <= done_s;
    end
  end
  assign start_rise = start_s && !start_prev_q;
  assign done_rise = done_s && !done_prev_q;

  // table write with range checks; entry 0 is never stored
  assign wr_ok = (tbl_wr_idx != pts_pkg::DIRECT_IDX) // RULE15
    && (tbl_wr_data.pos <= pts_pkg::POS_MAX) && (tbl_wr_data.pos >= pts_pkg::POS_MIN)
    && (tbl_wr_data.accel_ms <= pts_pkg::TIME_MAX_MS) // RULE4
    && (tbl_wr_data.decel_ms <= pts_pkg::TIME_MAX_MS) // RULE5
    && (tbl_wr_data.dwell_ms <= pts_pkg::TIME_MAX_MS) // RULE6
    && (tbl_wr_data.mcode <= pts_pkg::MCODE_MAX); // RULE9

  // memory has no reset: software loads it before the first start
  always_ff @(posedge clk) begin
    if (tbl_wr_en && wr_ok) tbl_q[tbl_wr_idx] <= tbl_wr_data;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) wr_reject_q <= 1'b0;
    else wr_reject_q <= tbl_wr_en && !wr_ok;
  end

  // entry 0 reads the remote-register values instead of the table
  assign ent_rd = (cur_idx_q == pts_pkg::DIRECT_IDX) ? direct_entry : tbl_q[cur_idx_q]; // RULE16

  // scale by ten to the exponent; products stay inside 32 bits for 999999*1000
  always_comb begin
    case (position_scale_exponent)
      2'h0: scaled = pts_pkg::CMD_W'(ent_rd.pos);
      2'h1: scaled = pts_pkg::CMD_W'(ent_rd.pos) * 32'sh0000_000a;
      2'h2: scaled = pts_pkg::CMD_W'(ent_rd.pos) * 32'sh0000_0064;
      default: scaled = pts_pkg::CMD_W'(ent_rd.pos) * 32'sh0000_03e8;
    endcase
  end
  assign inc_sum = present_pos_q + scaled; // RULE1
  assign target_d = abs_mode ? scaled : inc_sum; // RULE14
  assign inc_bad = !abs_mode && ent_rd.pos[pts_pkg::POS_W-1]; // RULE2

  // incremental accepts only code 1 for chaining, absolute any odd code
  assign chain_ok = abs_q ? ent_q.aux[0] : (ent_q.aux == pts_pkg::AUX_CHAIN); // RULE8 RULE10
  assign dwell_end = (state_q == pts_pkg::ST_DWELL) && (dwell_cnt_q == '0);

  // sequencer state, entry pointer and latched entry
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= pts_pkg::ST_IDLE;
      cur_idx_q <= pts_pkg::DIRECT_IDX;
      ent_q <= '0;
      abs_q <= 1'b0;
    end else begin
      case (state_q)
        pts_pkg::ST_IDLE: begin
          if (start_rise) begin // RULE17
            cur_idx_q <= sel_s; // RULE15
            state_q <= pts_pkg::ST_LOAD;
          end
        end
        pts_pkg::ST_LOAD: begin
          ent_q <= ent_rd;
          abs_q <= abs_mode;
          state_q <= inc_bad ? pts_pkg::ST_IDLE : pts_pkg::ST_MOVE;
        end
        pts_pkg::ST_MOVE: begin
          if (done_rise) state_q <= pts_pkg::ST_DWELL;
        end
        pts_pkg::ST_DWELL: begin
          if (dwell_cnt_q == '0) begin // RULE6
            // the remote entry and the last entry have no successor
            if (chain_ok && cur_idx_q != pts_pkg::LAST_IDX && cur_idx_q != pts_pkg::DIRECT_IDX) begin
              cur_idx_q <= cur_idx_q + 1'b1; // RULE8 RULE10
              state_q <= pts_pkg::ST_LOAD;
            end else begin
              state_q <= pts_pkg::ST_IDLE; // RULE7 RULE11
            end
          end
        end
        default: state_q <= pts_pkg::ST_IDLE;
      endcase
    end
  end

  // dwell counter in milliseconds, loaded when the move completes
  always_ff @(posedge clk) begin
    if (!rst_n) dwell_cnt_q <= '0;
    else if (tick_clr) dwell_cnt_q <= ent_q.dwell_ms; // RULE6
    else if (state_q == pts_pkg::ST_DWELL && tick && dwell_cnt_q != '0) dwell_cnt_q <= dwell_cnt_q - 1'b1;
  end

  // move command to the motion controller; S-curve time is the global setting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      move_cmd_q <= '0;
      move_start_q <= 1'b0;
    end else begin
      move_start_q <= 1'b0;
      if (state_q == pts_pkg::ST_LOAD && !inc_bad) begin
        move_cmd_q.target <= target_d; // RULE1 RULE14
        move_cmd_q.speed <= ent_rd.speed; // RULE3
        move_cmd_q.accel_ms <= ent_rd.accel_ms; // RULE4
        move_cmd_q.decel_ms <= ent_rd.decel_ms; // RULE5
        move_cmd_q.scurve_ms <= s_curve_ms; // RULE13
        move_start_q <= 1'b1;
      end
    end
  end

  // present position follows each completed target
  always_ff @(posedge clk) begin
    if (!rst_n) present_pos_q <= pts_pkg::RST_POS;
    else if (tick_clr) present_pos_q <= move_cmd_q.target;
  end

  // completion code only goes out when the extension digital outputs exist
  always_ff @(posedge clk) begin
    if (!rst_n || !ext_io_present) begin // RULE12
      mcode_q <= pts_pkg::RST_MCODE;
      mcode_valid_q <= 1'b0;
    end else if (tick_clr) begin
      mcode_q <= ent_q.mcode; // RULE9
      mcode_valid_q <= 1'b1;
    end else if (move_start_q) begin
      mcode_valid_q <= 1'b0;
    end
  end

  // status flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      pos_done_q <= 1'b0;
      entry_err_q <= 1'b0;
    end else begin
      busy_q <= (state_q != pts_pkg::ST_IDLE);
      pos_done_q <= tick_clr;
      // sticky until the next accepted start
      if (state_q == pts_pkg::ST_LOAD && inc_bad) entry_err_q <= 1'b1; // RULE2
      else if (state_q == pts_pkg::ST_IDLE && start_rise) entry_err_q <= 1'b0;
    end
  end

  AST_INC_TARGET: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    (state_q == pts_pkg::ST_LOAD && !abs_mode && !inc_bad) |=> (move_cmd_q.target == $past(inc_sum)))
    else $error("incremental target is not present position plus amount");
  AST_ABS_TARGET: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    (state_q == pts_pkg::ST_LOAD && abs_mode) |=> (move_cmd_q.target == $past(scaled)))
    else $error("absolute target is not the scaled address");
  AST_NEG_INC: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    (state_q == pts_pkg::ST_LOAD && inc_bad) |=> (state_q == pts_pkg::ST_IDLE && entry_err_q && !move_start_q))
    else $error("negative incremental amount was not refused");
  AST_MOVE_FIELDS: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    move_start_q |-> (move_cmd_q.speed == ent_q.speed && move_cmd_q.accel_ms == ent_q.accel_ms
      && move_cmd_q.decel_ms == ent_q.decel_ms && state_q == pts_pkg::ST_MOVE))
    else $error("move command fields differ from the running entry");
  AST_WR_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    (tbl_wr_en && tbl_wr_data.accel_ms > pts_pkg::TIME_MAX_MS) |=> wr_reject_q)
    else $error("out of range time constant was accepted");
  AST_DWELL: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    (state_q == pts_pkg::ST_DWELL ##1 state_q != pts_pkg::ST_DWELL) |-> ($past(dwell_cnt_q) == '0))
    else $error("dwell ended before its count ran out");
  AST_STOP: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    (dwell_end && !chain_ok) |=> (state_q == pts_pkg::ST_IDLE) ##1 (state_q != pts_pkg::ST_MOVE))
    else $error("stop code did not return to idle");
  AST_CHAIN_INC: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    (dwell_end && !abs_q && ent_q.aux == pts_pkg::AUX_CHAIN && cur_idx_q != pts_pkg::LAST_IDX
      && cur_idx_q != pts_pkg::DIRECT_IDX) |=> (state_q == pts_pkg::ST_LOAD && cur_idx_q == $past(cur_idx_q) + 8'h01))
    else $error("incremental chain did not advance");
  AST_CHAIN_ABS: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    (dwell_end && abs_q && ent_q.aux[0] && cur_idx_q != pts_pkg::LAST_IDX && cur_idx_q != pts_pkg::DIRECT_IDX)
      |=> ##1 move_start_q)
    else $error("absolute chain did not start the next move");
  AST_MCODE: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    (tick_clr && ext_io_present) |=> (mcode_valid_q && mcode_q == $past(ent_q.mcode) && pos_done_q))
    else $error("completion code not presented at finish");
  AST_NO_EXT: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    !ext_io_present |=> (!mcode_valid_q && mcode_q == pts_pkg::RST_MCODE))
    else $error("completion code driven without extension outputs");
  AST_SCURVE: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    (state_q == pts_pkg::ST_LOAD && !inc_bad) |=> (move_cmd_q.scurve_ms == $past(s_curve_ms)))
    else $error("s-curve time not taken from the global setting");
  AST_IGNORE_START: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    (state_q == pts_pkg::ST_MOVE && start_rise && !done_rise) |=> (state_q == pts_pkg::ST_MOVE
      && cur_idx_q == $past(cur_idx_q)))
    else $error("start accepted while busy");

  // refusals, selection and status flags: a silent drop here would only show as a wrong move much later
  AST_IGNORE_DWELL: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    (state_q == pts_pkg::ST_DWELL && dwell_cnt_q != '0 && start_rise) |=> (state_q == pts_pkg::ST_DWELL
      && cur_idx_q == $past(cur_idx_q)))
    else $error("start accepted during the dwell");
  AST_START_SEL: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    (state_q == pts_pkg::ST_IDLE && start_rise) |=> (state_q == pts_pkg::ST_LOAD && cur_idx_q == $past(sel_s)))
    else $error("accepted start did not take the selected entry");
  AST_DIRECT: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
    (state_q == pts_pkg::ST_LOAD && cur_idx_q == pts_pkg::DIRECT_IDX) |=> (ent_q == $past(direct_entry)))
    else $error("entry zero did not use the remote-register values");
  AST_WR_IDX0: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    (tbl_wr_en && tbl_wr_idx == pts_pkg::DIRECT_IDX) |=> wr_reject_q)
    else $error("write to entry zero was not refused");
  AST_WR_DECEL: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    (tbl_wr_en && tbl_wr_data.decel_ms > pts_pkg::TIME_MAX_MS) |=> wr_reject_q)
    else $error("out of range deceleration time was accepted");
  AST_WR_MCODE: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    (tbl_wr_en && tbl_wr_data.mcode > pts_pkg::MCODE_MAX) |=> wr_reject_q)
    else $error("out of range completion code was accepted");
  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    pos_done_q |=> !pos_done_q)
    else $error("positioning done lasted more than one cycle");
  AST_BUSY: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    (state_q != pts_pkg::ST_IDLE) |=> busy_q)
    else $error("busy not shown while the sequencer runs");
endmodule // pts_sequencer

// ===== inc/pts_pkg.sv
/*
  pts_pkg: constants, table entry layout, move command layout and sequencer states
  for the point-table positioning sequencer.
  assumes: a single 50 MHz clock; all users refer to names as pts_pkg::name.
*/
package pts_pkg;
  // clock and time base
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1; // dwell is counted in whole milliseconds
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // table geometry: entry 0 is the remote-register entry, 1..255 are stored
  localparam int ENTRIES = 255;
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] DIRECT_IDX = 8'h00;
  localparam logic [IDX_W-1:0] LAST_IDX = 8'hff;

  // field widths
  localparam int POS_W = 21;
  localparam int SPD_W = 16;
  localparam int TIME_W = 15;
  localparam int AUX_W = 2;
  localparam int MCODE_W = 7;
  localparam int CMD_W = 32;
  localparam int EXP_W = 2;

  // field limits
  localparam logic signed [POS_W-1:0] POS_MAX = 21'h0f423f; // 999999
  localparam logic signed [POS_W-1:0] POS_MIN = -POS_MAX;
  localparam logic [TIME_W-1:0] TIME_MAX_MS = 15'h4e20; // 20000 ms
  localparam logic [MCODE_W-1:0] MCODE_MAX = 7'h63; // 99

  // auxiliary codes
  localparam logic [AUX_W-1:0] AUX_STOP = 2'h0;
  localparam logic [AUX_W-1:0] AUX_CHAIN = 2'h1;

  // reset values
  localparam logic signed [CMD_W-1:0] RST_POS = 32'h0000_0000;
  localparam logic [MCODE_W-1:0] RST_MCODE = 7'h00;

  typedef struct packed {
    logic signed [POS_W-1:0] pos;
    logic [SPD_W-1:0] speed;
    logic [TIME_W-1:0] accel_ms;
    logic [TIME_W-1:0] decel_ms;
    logic [TIME_W-1:0] dwell_ms;
    logic [AUX_W-1:0] aux;
    logic [MCODE_W-1:0] mcode;
  } pts_entry_t;

  typedef struct packed {
    logic signed [CMD_W-1:0] target;
    logic [SPD_W-1:0] speed;
    logic [TIME_W-1:0] accel_ms;
    logic [TIME_W-1:0] decel_ms;
    logic [TIME_W-1:0] scurve_ms;
  } pts_move_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_MOVE,
    ST_DWELL
  } pts_state_t;
endpackage

// ===== core/pts_sync.sv
/*
  pts_sync: three-stage synchroniser per bit; the output takes a new value only
  once the second and third stages agree, which also rejects one-cycle glitches.
  assumes: din comes from outside the clk domain.
*/
`timescale 1ns/1ps
module pts_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic s1_q, s2_q, s3_q, out_q;
      // stage one is read by stage two only
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q <= din[b];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) out_q <= s3_q;
        end
      end
      assign dout[b] = out_q;
    end
  endgenerate
endmodule // pts_sync

// ===== core/pts_ms_tick.sv
/*
  pts_ms_tick: divider giving a one-cycle enable every CYCLES clocks.
  assumes: clear restarts the period so a dwell always counts whole milliseconds.
*/
`timescale 1ns/1ps
module pts_ms_tick #(
  parameter int CYCLES = pts_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  output logic tick
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] TOP = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_q;

  // free running between clears
  always_ff @(posedge clk) begin
    if (!rst_n || clear || cnt_q == TOP) cnt_q <= '0;
    else cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) tick <= 1'b0;
    else tick <= (cnt_q == TOP) && !clear;
  end
endmodule // pts_ms_tick

// ===== bench/pts_host_model.sv
/*
  pts_host_model: host and motion-controller side of the sequencer pins.
  assumes: one clk; the bench asks for starts with one-cycle strobes.
*/
`timescale 1ns/1ps
module pts_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_req,
  input wire logic [7:0] sel,
  input wire logic [7:0] done_dly,
  input wire logic move_start_q,
  output logic start_pin,
  output logic [7:0] point_sel_pin,
  output logic motion_done_pin
);
  int st_cnt;
  int mv_cnt;

  // entry number settles well before start rises, so the synchronisers agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_pin <= 1'b0;
      point_sel_pin <= 8'h00;
      st_cnt <= 0;
    end else if (start_req && st_cnt == 0) begin
      point_sel_pin <= sel;
      st_cnt <= 14;
    end else if (st_cnt > 0) begin
      st_cnt <= st_cnt - 1;
      start_pin <= (st_cnt <= 8) && (st_cnt > 2);
    end
  end

  // done is a short pulse so it has fallen before a chained move begins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      motion_done_pin <= 1'b0;
      mv_cnt <= 0;
    end else if (move_start_q) begin
      motion_done_pin <= 1'b0;
      mv_cnt <= int'(done_dly) + 6;
    end else if (mv_cnt > 0) begin
      mv_cnt <= mv_cnt - 1;
      motion_done_pin <= (mv_cnt <= 5) && (mv_cnt >= 2);
    end
  end
endmodule // pts_host_model

// ===== bench/pts_sequencer_tb.sv
/*
  pts_sequencer_tb: self-checking bench for the point-table sequencer.
  assumes: pts_host_model drives the pins; the millisecond tick is cut to TICK clocks.
*/
`timescale 1ns/1ps
module pts_sequencer_tb;
  localparam int TICK = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_req = 1'b0;
  logic [7:0] sel = 8'h00;
  logic [7:0] done_dly = 8'h02;
  logic abs_mode = 1'b0;
  logic [1:0] exp_sc = 2'h1;
  logic [14:0] s_curve_ms = 15'h0007;
  logic ext_io_present = 1'b1;
  logic tbl_wr_en = 1'b0;
  logic [7:0] tbl_wr_idx = 8'h00;
  pts_pkg::pts_entry_t direct_entry = '0;
  pts_pkg::pts_entry_t tbl_wr_data = '0;
  pts_pkg::pts_entry_t tbl [256];
  pts_pkg::pts_move_t move_cmd_q;
  logic start_pin, motion_done_pin, move_start_q, busy_q, mcode_valid_q, pos_done_q, wr_reject_q, entry_err_q;
  logic [7:0] point_sel_pin, cur_idx_q, ri;
  logic [6:0] mcode_q;
  logic signed [31:0] present_pos_q;
  logic signed [31:0] exp_pos = 32'sh0000_0000;
  logic [31:0] rng = 32'h0000_a4f9;
  int num_errors = 0;
  int comparisons = 0;
  int waited;
  logic poke = 1'b0; // when set, expect_move fires a start while the move runs

  always #10 clk = ~clk;

  pts_host_model u_host (.clk(clk), .rst_n(rst_n), .start_req(start_req), .sel(sel), .done_dly(done_dly),
    .move_start_q(move_start_q), .start_pin(start_pin), .point_sel_pin(point_sel_pin),
    .motion_done_pin(motion_done_pin));

  pts_sequencer #(.TICK_CYCLES(TICK)) u_dut (.clk(clk), .rst_n(rst_n), .start_pin(start_pin),
    .point_sel_pin(point_sel_pin), .motion_done_pin(motion_done_pin), .abs_mode(abs_mode),
    .position_scale_exponent(exp_sc), .s_curve_ms(s_curve_ms), .ext_io_present(ext_io_present),
    .direct_entry(direct_entry), .tbl_wr_en(tbl_wr_en), .tbl_wr_idx(tbl_wr_idx), .tbl_wr_data(tbl_wr_data),
    .move_cmd_q(move_cmd_q), .move_start_q(move_start_q), .busy_q(busy_q), .cur_idx_q(cur_idx_q),
    .present_pos_q(present_pos_q), .mcode_q(mcode_q), .mcode_valid_q(mcode_valid_q), .pos_done_q(pos_done_q),
    .wr_reject_q(wr_reject_q), .entry_err_q(entry_err_q));

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic pts_pkg::pts_entry_t mk(int p, int s, int a, int d, int w, int x, int m);
    return {21'(p), 16'(s), 15'(a), 15'(d), 15'(w), 2'(x), 7'(m)};
  endfunction

  // absolute targets ignore where the axis stands; incremental ones add to it
  function automatic logic signed [31:0] tgt(pts_pkg::pts_entry_t n);
    logic signed [31:0] s;
    s = 32'(n.pos) * (exp_sc == 2'h0 ? 1 : exp_sc == 2'h1 ? 10 : exp_sc == 2'h2 ? 100 : 1000);
    return abs_mode ? s : exp_pos + s;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] expv);
    comparisons++;
    if (seen !== expv) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask

  // a refused write pulses once within the two edges after the strobe
  task automatic wr(input logic [7:0] idx, input pts_pkg::pts_entry_t d, input logic bad);
    int r;
    @(posedge clk);
    tbl_wr_en <= 1'b1;
    tbl_wr_idx <= idx;
    tbl_wr_data <= d;
    @(posedge clk);
    tbl_wr_en <= 1'b0;
    #1;
    r = int'(wr_reject_q);
    @(posedge clk);
    #1;
    r = r + int'(wr_reject_q);
    check(r, bad);
    if (!bad) tbl[idx] = d;
  endtask

  task automatic start(input logic [7:0] s);
    @(posedge clk);
    start_req <= 1'b1;
    sel <= s;
    @(posedge clk);
    start_req <= 1'b0;
  endtask

  task automatic expect_move(input logic [7:0] idx);
    int n;
    logic signed [31:0] t;
    pts_pkg::pts_entry_t x;
    x = (idx == 8'h00) ? direct_entry : tbl[idx];
    t = tgt(x);
    waited = 0;
    n = 0;
    while (move_start_q !== 1'b1 && waited < 500) begin
      @(posedge clk);
      #1;
      waited++;
    end
    check(move_start_q, 1'b1);
    check(move_cmd_q.target, t);
    check({move_cmd_q.speed, move_cmd_q.accel_ms, move_cmd_q.decel_ms}, {x.speed, x.accel_ms, x.decel_ms});
    check(move_cmd_q.scurve_ms, s_curve_ms);
    check(cur_idx_q, idx);
    if (poke) start(8'h01);
    while (pos_done_q !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    exp_pos = t;
    check(present_pos_q, t);
    check(mcode_q, ext_io_present ? x.mcode : 7'h00);
    check(pos_done_q, 1'b1);
    check(mcode_valid_q, ext_io_present);
  endtask

  // long enough to cover any dwell the tests use plus a would-be chained move
  task automatic expect_idle();
    int moves;
    moves = 0;
    repeat (120) begin
      @(posedge clk);
      #1;
      if (move_start_q === 1'b1) moves++;
    end
    check(moves, 0);
    check(busy_q, 1'b0);
  endtask

  task automatic end_test(input string name);
    $display("test %s finished, errors so far %0d", name, num_errors);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 256; i++) tbl[i] = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    // upper field limits accepted except the dwell's, one step past each upper limit refused
    wr(8'h01, mk(999999, 2000, 20000, 20000, 0, 1, 99), 1'b0);
    wr(8'h02, mk(1000, 1600, 100, 100, 3, 1, 2), 1'b0);
    wr(8'h03, mk(500, 3000, 0, 0, 0, 0, 0), 1'b0);
    wr(8'h05, mk(7, 10, 1, 2, 10, 0, 5), 1'b0);
    wr(8'h06, mk(-5000, 100, 5, 5, 0, 2, 6), 1'b0);
    wr(8'h07, mk(300, 200, 5, 5, 0, 3, 7), 1'b0);
    wr(8'h08, mk(-40, 200, 5, 5, 0, 1, 8), 1'b0);
    wr(8'h09, mk(900, 200, 5, 5, 1, 0, 9), 1'b0);
    wr(8'hff, mk(3000, 3000, 100, 100, 0, 1, 99), 1'b0);
    wr(8'h00, mk(1, 1, 1, 1, 0, 0, 1), 1'b1);
    wr(8'h04, mk(1000000, 1, 1, 1, 0, 0, 1), 1'b1);
    wr(8'h04, mk(1, 1, 20001, 1, 0, 0, 1), 1'b1);
    wr(8'h04, mk(1, 1, 1, 20001, 0, 0, 1), 1'b1);
    wr(8'h04, mk(1, 1, 1, 1, 20001, 0, 1), 1'b1);
    wr(8'h04, mk(1, 1, 1, 1, 0, 0, 100), 1'b1);
    end_test("writes");
    // incremental chain 1 -> 2 -> (dwell) -> 3, then stop
    start(8'h01);
    expect_move(8'h01);
    expect_move(8'h02);
    expect_move(8'h03);
    check(waited >= 3 * TICK && waited <= 3 * TICK + 8, 1'b1);
    expect_idle();
    // restart after a stop, completion code outputs absent
    @(posedge clk);
    ext_io_present <= 1'b0;
    start(8'h03);
    expect_move(8'h03);
    expect_idle();
    @(posedge clk);
    ext_io_present <= 1'b1;
    done_dly <= 8'h28;
    // starts arriving during a long move and during the dwell are dropped
    poke = 1'b1;
    start(8'h05);
    expect_move(8'h05);
    poke = 1'b0;
    done_dly <= 8'h02;
    start(8'h01);
    expect_idle();
    end_test("incremental");
    @(posedge clk);
    abs_mode <= 1'b1;
    exp_sc <= 2'h2;
    start(8'h06);
    expect_move(8'h06);
    expect_idle();
    start(8'h07);
    expect_move(8'h07);
    expect_move(8'h08);
    expect_move(8'h09);
    expect_idle();
    // last entry and the remote-register entry never chain
    start(8'hff);
    expect_move(8'hff);
    expect_idle();
    @(posedge clk);
    direct_entry <= mk(-20, 50, 3, 4, 0, 1, 42);
    start(8'h00);
    expect_move(8'h00);
    expect_idle();
    end_test("absolute");
    // a negative amount is refused in incremental mode
    @(posedge clk);
    abs_mode <= 1'b0;
    start(8'h00);
    expect_idle();
    check(entry_err_q, 1'b1);
    end_test("negative amount");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      abs_mode <= 1'(rnd());
      exp_sc <= 2'(rnd());
      done_dly <= 8'(rnd() % 64);
      ri = 8'(1 + rnd() % 254);
      wr(ri, mk(rnd() % 100000, rnd() % 4000, rnd() % 20001, rnd() % 20001, rnd() % 3, 0, rnd() % 100), 1'b0);
      start(ri);
      expect_move(ri);
      expect_idle();
    end
    end_test("random");
    stop_test();
  end

  // the whole run needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule // pts_sequencer_tb
